// ### design/fcd_cfg.svh
// constants for the fast charge voltage command decoder
// Behaviour
// R1 - sensed current above 250mA counts as a high symbol.
// R2 - sensed current below 130mA counts as a low symbol.
// R3 - a command is a level sequence matching the raise, lower, test or cycle pattern only.
// R4 - setpoint starts at 5V after reset and holds until a valid command.
// R5 - no handshake; a valid pattern is accepted at any time.
// R6 - raise steps 5V to 7V, 9V, 12V and stops at 12V.
// R7 - lower steps down 200mV per command, stopping at 3.6V; above 5V the code drops straight to 5V.
// R8 - current below 130mA for 220ms forces setpoint back to 5V.
// R9 - the phone removes load and waits 220ms to get 5V back.
// R10 - current limit rises at lower voltage and falls at higher voltage.
// R11 - a test pattern enters test mode; a cycle pattern steps the levels.
// R12 - after the full range in test mode, leave test mode at 5V.
// R13 - test equipment holds each test step 100ms before measuring.
// R14 - commands arrive only as load current, never over data lines.
// R15 - symbol widths and tolerances come from configurable constants.
// R16 - a deviating partial sequence is dropped; only full matches act.
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
`define FCD_CLK_MHZ 100
`define FCD_HI_MA 16'h00FA
`define FCD_LO_MA 16'h0082
`define FCD_WDOG_MS 220
`define FCD_WDOG_CYC (`FCD_WDOG_MS * 1000 * `FCD_CLK_MHZ)
`define FCD_SYM_US 100
`define FCD_SYM_CYC (`FCD_SYM_US * `FCD_CLK_MHZ)
`define FCD_SYM_TOL_US 20
`define FCD_SYM_TOL_CYC (`FCD_SYM_TOL_US * `FCD_CLK_MHZ)
`define FCD_PAT_LEN 8
`define FCD_PAT_RAISE 8'hB2
`define FCD_PAT_LOWER 8'h4D
`define FCD_PAT_TEST 8'hE1
`define FCD_PAT_CYCLE 8'h1E
`define FCD_MV_DEFAULT 16'h1388
`define FCD_MV_FLOOR 16'h0E10
`define FCD_MV_STEP 16'h00C8
`define FCD_MV_7V 16'h1B58
`define FCD_MV_9V 16'h2328
`define FCD_MV_12V 16'h2EE0
`define FCD_ILIM_5V 16'h0BB8
`define FCD_PWR_MW 32'h0000_3A98
`endif

// ### design/fcd_pkg.sv
// types for the fast charge voltage command decoder
package fcd_pkg;
	typedef enum logic [1:0] {FCD_SYM_IDLE, FCD_SYM_LOW, FCD_SYM_HIGH} fcd_lvl_t;
	typedef enum logic [2:0] {FCD_CMD_NONE, FCD_CMD_RAISE, FCD_CMD_LOWER, FCD_CMD_TEST,
		FCD_CMD_CYCLE} fcd_cmd_t;
	typedef struct packed {
		logic [15:0] setpoint_mv;
		logic [15:0] ilimit_ma;
		logic test_mode;
	} fcd_out_t;
endpackage

// ### design/fcd_decoder.sv
// fast charge command decoder and voltage setpoint holder
`timescale 1ns/1ps
`include "fcd_cfg.svh"
module fcd_decoder #(
	parameter int unsigned WDOG_CYC = `FCD_WDOG_CYC,
	parameter int unsigned SYM_CYC = `FCD_SYM_CYC,
	parameter int unsigned SYM_TOL_CYC = `FCD_SYM_TOL_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [15:0] sense_ma,
	output fcd_pkg::fcd_out_t status,
	output logic cmd_pulse
);
	// pin sample: current measurement comes from the analog path
	logic [15:0] s1_r, s2_r;
	always_ff @(posedge clock) begin
		if (reset) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
		end else begin
			s1_r <= sense_ma;
			s2_r <= s1_r;
		end
	end

	// level classifier; between thresholds gives idle, so no level change is seen
	fcd_pkg::fcd_lvl_t lvl;
	always_comb begin
		if (s2_r > `FCD_HI_MA) lvl = fcd_pkg::FCD_SYM_HIGH; // R1
		else if (s2_r < `FCD_LO_MA) lvl = fcd_pkg::FCD_SYM_LOW; // R2
		else lvl = fcd_pkg::FCD_SYM_IDLE;
	end

	// symbol timing and shift register
	logic cur_hi_r, cur_hi_nxt;
	logic [31:0] run_r, run_nxt;
	logic [7:0] shf_r, shf_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [31:0] quiet_r, quiet_nxt;
	fcd_pkg::fcd_cmd_t cmd;
	logic wdog_fire;

	// word framing on the sensed current:
	// idle is low current, so the word starts at its first high symbol
	// leading low symbols of a word merge with the idle low before it
	// so a word is matched as soon as its recorded bits equal a pattern
	// whose upper, unrecorded bits are all zero
	// a symbol is recorded only when its level changes away,
	// so the sender must finish every word with a trailing level change
	// a run of n symbols must last n symbol times within the tolerance,
	// otherwise the partial word is dropped and matching starts again
	// no pattern is a recorded prefix of another, so an early match is safe
	// hazard: a long low run is idle only while no bit is recorded yet

	// whole symbols in a run, zero when off the grid by more than the tolerance
	function automatic logic [31:0] sym_count(input logic [31:0] len); // R15
		logic [31:0] n;
		n = 32'h0000_0000;
		if (len + SYM_TOL_CYC >= SYM_CYC) n = (len + SYM_TOL_CYC) / SYM_CYC;
		if (n != 32'h0000_0000 && (len + SYM_TOL_CYC - n * SYM_CYC) > 2 * SYM_TOL_CYC)
			n = 32'h0000_0000;
		sym_count = n;
	endfunction

	// recorded word to command code
	function automatic fcd_pkg::fcd_cmd_t match(input logic [7:0] p);
		if (p == `FCD_PAT_RAISE) match = fcd_pkg::FCD_CMD_RAISE;
		else if (p == `FCD_PAT_LOWER) match = fcd_pkg::FCD_CMD_LOWER;
		else if (p == `FCD_PAT_TEST) match = fcd_pkg::FCD_CMD_TEST;
		else if (p == `FCD_PAT_CYCLE) match = fcd_pkg::FCD_CMD_CYCLE;
		else match = fcd_pkg::FCD_CMD_NONE;
	endfunction

	logic edge_seen;
	logic [31:0] nsym;
	logic idle_end;
	logic width_bad;
	// level change seen and the width of the run that it ends
	assign edge_seen = (lvl == fcd_pkg::FCD_SYM_HIGH && !cur_hi_r) ||
		(lvl == fcd_pkg::FCD_SYM_LOW && cur_hi_r);
	assign nsym = sym_count(run_r + 32'h0000_0001);
	// low run before the first high of a word is idle, of any width
	assign idle_end = (cnt_r == 4'h0) && !cur_hi_r;
	// run that is no whole number of symbols spoils the word
	assign width_bad = (nsym == 32'h0000_0000) || (nsym > 32'h0000_0008); // R15 R16

	// each run of a level, except the idle low run, is cut into whole symbols; any bad width restarts matching
	always_comb begin
		cur_hi_nxt = cur_hi_r;
		run_nxt = run_r + 32'h0000_0001;
		shf_nxt = shf_r;
		cnt_nxt = cnt_r;
		cmd = fcd_pkg::FCD_CMD_NONE;
		if (edge_seen) begin
			cur_hi_nxt = !cur_hi_r;
			run_nxt = 32'h0000_0000;
			if (idle_end) begin
				shf_nxt = 8'h00; // nothing recorded from idle
				cnt_nxt = 4'h0;
			end else if (width_bad) begin
				shf_nxt = 8'h00; // R16
				cnt_nxt = 4'h0; // R16
			end else begin
				for (int i = 0; i < 8; i++) begin
					if (32'(i) < nsym && cnt_nxt < 4'(`FCD_PAT_LEN)) begin
						shf_nxt = {shf_nxt[6:0], cur_hi_r};
						cnt_nxt = cnt_nxt + 4'h1;
					end
				end
				cmd = match(shf_nxt); // R3 R5 R14
				if (cmd != fcd_pkg::FCD_CMD_NONE || cnt_nxt >= 4'(`FCD_PAT_LEN)) begin
					shf_nxt = 8'h00;
					cnt_nxt = 4'h0; // R16
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cur_hi_r <= 1'b0;
			run_r <= 32'h0000_0000;
			shf_r <= 8'h00;
			cnt_r <= 4'h0;
		end else begin
			cur_hi_r <= cur_hi_nxt;
			run_r <= run_nxt;
			shf_r <= shf_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// watchdog on continuous low current
	always_comb begin
		if (lvl == fcd_pkg::FCD_SYM_LOW) begin
			quiet_nxt = (quiet_r < WDOG_CYC) ? quiet_r + 32'h0000_0001 : quiet_r; // R8
		end else begin
			quiet_nxt = 32'h0000_0000;
		end
	end
	assign wdog_fire = (quiet_r == WDOG_CYC - 1) && (lvl == fcd_pkg::FCD_SYM_LOW); // R8

	always_ff @(posedge clock) begin
		if (reset) quiet_r <= 32'h0000_0000;
		else quiet_r <= quiet_nxt;
	end

	// setpoint, test mode and current limit
	logic [15:0] mv_r, mv_nxt;
	logic tm_r, tm_nxt;
	logic [15:0] il_r, il_nxt;
	logic cp_r, cp_nxt;

	// next higher setpoint level, held at the top
	function automatic logic [15:0] step_up(input logic [15:0] mv);
		if (mv < `FCD_MV_DEFAULT) step_up = `FCD_MV_DEFAULT;
		else if (mv < `FCD_MV_7V) step_up = `FCD_MV_7V;
		else if (mv < `FCD_MV_9V) step_up = `FCD_MV_9V;
		else step_up = `FCD_MV_12V; // R6
	endfunction

	always_comb begin
		mv_nxt = mv_r;
		tm_nxt = tm_r;
		cp_nxt = (cmd != fcd_pkg::FCD_CMD_NONE);
		if (wdog_fire) begin
			mv_nxt = `FCD_MV_DEFAULT; // R8
			tm_nxt = 1'b0;
		end else if (tm_r) begin
			if (cmd == fcd_pkg::FCD_CMD_CYCLE) begin // R11
				if (mv_r >= `FCD_MV_12V) begin
					mv_nxt = `FCD_MV_DEFAULT; // R12
					tm_nxt = 1'b0; // R12
				end else if (mv_r > `FCD_MV_FLOOR && mv_r <= `FCD_MV_DEFAULT) begin
					mv_nxt = mv_r - `FCD_MV_STEP;
				end else if (mv_r == `FCD_MV_FLOOR) begin
					mv_nxt = `FCD_MV_7V;
				end else begin
					mv_nxt = step_up(mv_r);
				end
			end
		end else begin
			unique case (cmd)
				fcd_pkg::FCD_CMD_RAISE: mv_nxt = step_up(mv_r); // R6
				fcd_pkg::FCD_CMD_LOWER: begin
					if (mv_r > `FCD_MV_DEFAULT) mv_nxt = `FCD_MV_DEFAULT;
					else if (mv_r > `FCD_MV_FLOOR) mv_nxt = mv_r - `FCD_MV_STEP; // R7
				end
				fcd_pkg::FCD_CMD_TEST: begin
					tm_nxt = 1'b1; // R11
					mv_nxt = `FCD_MV_DEFAULT;
				end
				fcd_pkg::FCD_CMD_CYCLE, fcd_pkg::FCD_CMD_NONE: mv_nxt = mv_r;
			endcase
		end
		// constant power limit referenced to 5V calibration
		il_nxt = 16'(`FCD_PWR_MW * 1000 / {16'h0000, mv_nxt}); // R10
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			mv_r <= `FCD_MV_DEFAULT; // R4
			tm_r <= 1'b0;
			il_r <= `FCD_ILIM_5V;
			cp_r <= 1'b0;
		end else begin
			mv_r <= mv_nxt;
			tm_r <= tm_nxt;
			il_r <= il_nxt;
			cp_r <= cp_nxt;
		end
	end

	// outputs straight from the registers
	assign status.setpoint_mv = mv_r;
	assign status.ilimit_ma = il_r;
	assign status.test_mode = tm_r;
	assign cmd_pulse = cp_r;
endmodule

// ### bench/fcd_assertions.sv
// port assertions for the command decoder
`timescale 1ns/1ps
module fcd_assertions #(
	parameter int unsigned WDOG_CYC = 2000
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [15:0] sense_ma,
	input wire fcd_pkg::fcd_out_t status,
	input wire logic cmd_pulse
);
	logic [31:0] lo_cnt_r;
	logic [31:0] lo_cnt_nxt;
	// length of the current low run
	always_comb begin
		lo_cnt_nxt = (sense_ma < 16'h0082) ? lo_cnt_r + 32'h0000_0001 : 32'h0000_0000;
	end
	always_ff @(posedge clock) begin
		lo_cnt_r <= reset ? 32'h0000_0000 : lo_cnt_nxt;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// pulse of one cycle
	sequence lone_pulse_s;
		cmd_pulse ##1 !cmd_pulse;
	endsequence
	reset_vals_a: assert property ($past(reset) |-> !cmd_pulse && status.setpoint_mv == 16'h1388)
		else $error("reset state wrong");
	setpoint_hold_a: assert property ($changed(status.setpoint_mv) |-> cmd_pulse || lo_cnt_r >= WDOG_CYC)
		else $error("setpoint moved without cause");
	wdog_restore_a: assert property (lo_cnt_r == WDOG_CYC + 8 |-> status.setpoint_mv == 16'h1388 && !status.test_mode)
		else $error("watchdog did not restore");
	limit_power_a: assert property (status.ilimit_ma == 32'h00E4_E1C0 / status.setpoint_mv)
		else $error("current limit wrong");
	setpoint_range_a: assert property (status.setpoint_mv inside {[16'h0E10:16'h2EE0]})
		else $error("setpoint out of range");
	pulse_single_a: assert property (cmd_pulse |-> lone_pulse_s)
		else $error("pulse too long");
	lower_step_a: assert property (cmd_pulse && status.setpoint_mv < 16'h1388 |->
		($past(status.setpoint_mv) - status.setpoint_mv) inside {16'h0000, 16'h00C8})
		else $error("lower step wrong");
	raise_levels_a: assert property (cmd_pulse && status.setpoint_mv > 16'h1388 |->
		status.setpoint_mv inside {16'h1B58, 16'h2328, 16'h2EE0})
		else $error("raise level wrong");
	test_entry_a: assert property ($rose(status.test_mode) |-> status.setpoint_mv == 16'h1388)
		else $error("test entry not at default");
	test_exit_a: assert property ($fell(status.test_mode) |-> status.setpoint_mv == 16'h1388)
		else $error("test exit not at default");
endmodule
bind fcd_decoder fcd_assertions #(.WDOG_CYC(WDOG_CYC)) chk (.clock(clock), .reset(reset),
	.sense_ma(sense_ma), .status(status), .cmd_pulse(cmd_pulse));

// ### bench/fcd_phone.sv
// phone model drawing coded load current
`timescale 1ns/1ps
module fcd_phone #(
	parameter int SYM_CYC = 20
) (
	input wire logic clock,
	output logic [15:0] sense_ma
);
	logic [15:0] hi_ma = 16'h012C;
	logic [15:0] lo_ma = 16'h0064;
	initial sense_ma = 16'h0064;
	// hold one level for a number of cycles
	task automatic level(input logic b, input int cyc);
		@(posedge clock);
		#1 sense_ma = b ? hi_ma : lo_ma;
		repeat (cyc - 1) @(posedge clock);
	endtask
	// pattern msb first, no preamble, then a trailing edge and idle
	task automatic send(input logic [7:0] pat);
		for (int i = 7; i >= 0; i--) level(pat[i], SYM_CYC);
		level(!pat[0], SYM_CYC);
		level(1'b0, 70);
	endtask
endmodule

// ### bench/fcd_decoder_tb.sv
// testbench for the command decoder
`timescale 1ns/1ps
module fcd_decoder_tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [15:0] sense_ma;
	fcd_pkg::fcd_out_t status;
	logic cmd_pulse;
	int n_errors = 0;
	int checked = 0;
	int n_pulse = 0;
	logic [23:0] rows [12] = '{24'hB2_2328, 24'hB2_2EE0, 24'hB2_2EE0, 24'h4D_1388, 24'h4D_12C0,
		24'h4D_11F8, 24'h4D_1130, 24'h4D_1068, 24'h4D_0FA0, 24'h4D_0ED8, 24'h4D_0E10, 24'h4D_0E10};
	logic [15:0] cyc [11] = '{16'h12C0, 16'h11F8, 16'h1130, 16'h1068, 16'h0FA0, 16'h0ED8,
		16'h0E10, 16'h1B58, 16'h2328, 16'h2EE0, 16'h1388};
	always #5 clock = ~clock;
	always @(negedge clock) if (cmd_pulse === 1'b1) n_pulse++;
	fcd_decoder #(.WDOG_CYC(2000), .SYM_CYC(20), .SYM_TOL_CYC(4)) dut (.clock(clock),
		.reset(reset), .sense_ma(sense_ma), .status(status), .cmd_pulse(cmd_pulse));
	fcd_phone #(.SYM_CYC(20)) ph (.clock(clock), .sense_ma(sense_ma));
	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_out(input logic [15:0] sp, input logic tm);
		check("setpoint", status.setpoint_mv, sp);
		check("ilimit", status.ilimit_ma, 16'(32'h00E4_E1C0 / sp));
		check("test_mode", {15'h0000, status.test_mode}, {15'h0000, tm});
	endtask
	task automatic go(input logic [7:0] pat, input logic [15:0] sp, input logic tm, input int np);
		int p;
		p = n_pulse;
		ph.send(pat);
		#1;
		check("pulses", 16'(n_pulse - p), 16'(np));
		chk_out(sp, tm);
		$display("test %h done", pat);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge clock);
		#1 reset = 1'b0;
		chk_out(16'h1388, 1'b0);
		ph.hi_ma = 16'h00FB;
		ph.lo_ma = 16'h0081;
		go(8'hB2, 16'h1B58, 1'b0, 1);
		ph.hi_ma = 16'h012C;
		ph.lo_ma = 16'h0064;
		foreach (rows[i]) go(rows[i][23:16], rows[i][15:0], 1'b0, 1);
		go(8'hAA, 16'h0E10, 1'b0, 0);
		go(8'hE1, 16'h1388, 1'b1, 1);
		foreach (cyc[k]) go(8'h1E, cyc[k], k < 10, 1);
		go(8'hB2, 16'h1B58, 1'b0, 1);
		reset = 1'b1;
		repeat (2) @(posedge clock);
		#1 reset = 1'b0;
		chk_out(16'h1388, 1'b0);
		$display("mid reset test done");
		go(8'hB2, 16'h1B58, 1'b0, 1);
		ph.level(1'b0, 2200);
		#1;
		chk_out(16'h1388, 1'b0);
		$display("watchdog test done");
		report_and_stop();
	end
endmodule
